// File: strobe_sync_device.sv
// Converter end: strobe latching, input buffer, oscillator and coarse mixer sync.
// Assumes the source end runs on pclk, which stands for the sample-rate clock.
//
// Behaviour
// [R1] Single clock unbuffered: rate edge chosen by invert.
// [R2] Single clock: rate clock divides sample clock.
// [R3] Single clock buffered: source initialises buffer first.
// [R4] Dual unbuffered: input clock latches, phases tight.
// [R5] Dual buffered: input clock latches, buffer crosses.
// [R6] PLL on: buffer bypassed, input clock latches.
// [R7] Strobe travels through buffer, delay may vary.
// [R8] Oscillator sync only when its enable set.
// [R9] Strobe rising edge resets phase accumulator.
// [R10] Accumulator clears 13 oscillator cycles after edge.
// [R11] Strobe to output latency roughly hundred cycles; here only a short pipeline.
// [R12] Coarse mixer complements samples, counter sequences.
// [R13] Mixer strobe comes from buffer output.
// [R14] Mixer counter reset only when enable set.
// [R15] Counter held while strobe low, runs high.
// [R16] Strobe high one write clock suffices.
// [R17] Start phase selects mixer reset state.
// [R18] Mixer select low bits shift phase likewise.
// [R19] PLL mode strobe sync is fully deterministic.
// [R20] Dual unbuffered clocks stay edge aligned.
// [R21] Buffer init sets pointer separation two.
// [R22] Accumulator reset to zero, then resumes.
`timescale 1ns/1ps
module strobe_sync_device
  import sync_pkg::*;
(
  input  wire logic        pclk,     // sample-rate clock
  input  wire logic        presetn,  // async reset, low active
  sync_link_if.device      link,     // link to source
  output logic      [15:0] dac_a,    // channel A output word
  output logic      [15:0] dac_b,    // channel B output word
  output logic      [31:0] osc_phase // oscillator accumulator
);

  // Complex coarse mix of one sample pair at a given phase.
  function automatic logic [31:0] mix(input logic [1:0] mode, input logic [1:0] ph,
                                      input logic [15:0] a, input logic [15:0] b);
    logic [15:0] na;
    logic [15:0] nb;
    logic [1:0]  q;
    na = 16'h0000 - a;
    nb = 16'h0000 - b;
    q  = (mode == MIX_NQUARTER) ? 2'h0 - ph : ph;
    mix = {b, a};
    if (mode == MIX_HALF) begin
      mix = ph[0] ? {nb, na} : {b, a};
    end else if (mode != MIX_OFF) begin
      case (q)
        2'h0:    mix = {b, a};
        2'h1:    mix = {a, nb};
        2'h2:    mix = {nb, na};
        default: mix = {na, b};
      endcase
    end
  endfunction

  logic [3:0]  div_cnt_reg;
  logic        rate_clk_reg;
  logic        inclk_prev_reg;
  logic        osc_half_reg;
  logic        lat_st_reg;
  logic [15:0] lat_a_reg;
  logic [15:0] lat_b_reg;
  logic        st_mem [BUF_DEPTH];
  logic [15:0] a_mem  [BUF_DEPTH];
  logic [15:0] b_mem  [BUF_DEPTH];
  logic [1:0]  wr_ptr_reg;
  logic [1:0]  rd_ptr_reg;
  logic        st_out_reg;
  logic [15:0] a_out_reg;
  logic [15:0] b_out_reg;
  logic        st_prev_reg;
  logic [3:0]  pend_reg;
  logic [31:0] acc_reg;
  logic [1:0]  cm_cnt_reg;
  logic [15:0] dac_a_reg;
  logic [15:0] dac_b_reg;

  wire pll_mode    = link.pll_supply_pin;
  wire single_mode = !pll_mode && !link.two_clock_select;
  // The buffer is forced out in PLL mode even if the source forgets.
  wire use_buffer  = !pll_mode && !link.buffer_skip; // [R6]
  // In dual or PLL mode without the buffer the input clock sets the divider phase.
  wire align_div   = !single_mode && !use_buffer; // [R4] [R19]

  wire [3:0] div_n     = div_of(link.interp_mode);
  wire       inclk_rise = link.input_rate_clock && !inclk_prev_reg;
  wire       rate_rise = (div_cnt_reg == div_n - 4'h1);
  wire       rate_fall = (div_cnt_reg == (div_n >> 1) - 4'h1);
  wire       out_tick  = align_div ? inclk_rise : rate_rise;
  wire [3:0] div_next  = (out_tick || (div_cnt_reg >= div_n - 4'h1)) ? 4'h0
                                                                     : div_cnt_reg + 4'h1;

  // Single modes latch on the rate clock edge picked by edge invert.
  wire single_ev = link.edge_invert ? rate_fall : rate_rise; // [R1] [R3]
  wire latch_ev  = single_mode ? single_ev : inclk_rise; // [R4] [R5] [R6]

  // Strobe and words after the buffer or the bypass register.
  wire        st_src = use_buffer ? st_mem[rd_ptr_reg] : lat_st_reg; // [R7]
  wire [15:0] a_src  = use_buffer ? a_mem[rd_ptr_reg] : lat_a_reg;
  wire [15:0] b_src  = use_buffer ? b_mem[rd_ptr_reg] : lat_b_reg;

  // The oscillator runs at full rate only in plain 4x mode.
  wire osc_tick   = (link.interp_mode == INTERP_4X) || osc_half_reg; // [R10]
  wire st_rise    = st_out_reg && !st_prev_reg && link.osc_sync_enable; // [R8] [R9]
  wire acc_clear  = osc_tick && (pend_reg == 4'h1); // [R10]
  wire cm_hold    = link.fixed_mixer_sync_enable && !st_out_reg; // [R14] [R15]
  wire [1:0] cm_ph = cm_cnt_reg + link.start_phase + link.fixed_mixer_select[1:0]; // [R17] [R18]
  wire [31:0] mixed = mix(link.fixed_mixer_select[3:2], cm_ph, a_out_reg, b_out_reg); // [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg    <= 4'h0;
      rate_clk_reg   <= 1'b0;
      inclk_prev_reg <= 1'b0;
      osc_half_reg   <= 1'b0;
    end else begin
      div_cnt_reg    <= div_next; // [R2]
      rate_clk_reg   <= (div_next < (div_n >> 1)); // [R2]
      inclk_prev_reg <= link.input_rate_clock;
      osc_half_reg   <= !osc_half_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_st_reg <= 1'b0;
      lat_a_reg  <= 16'h0000;
      lat_b_reg  <= 16'h0000;
    end else if (latch_ev) begin
      lat_st_reg <= link.phase_strobe;
      lat_a_reg  <= link.word_a;
      lat_b_reg  <= link.word_b;
    end
  end

  // Buffer storage carries no reset; pointers are set by initialisation.
  always_ff @(posedge pclk) begin
    if (latch_ev) begin
      st_mem[wr_ptr_reg] <= link.phase_strobe;
      a_mem[wr_ptr_reg]  <= link.word_a;
      b_mem[wr_ptr_reg]  <= link.word_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= INIT_WR_PTR;
      rd_ptr_reg <= INIT_RD_PTR;
    end else if (link.buffer_init) begin
      wr_ptr_reg <= INIT_WR_PTR; // [R21]
      rd_ptr_reg <= INIT_RD_PTR; // [R21]
    end else begin
      wr_ptr_reg <= wr_ptr_reg + {1'b0, latch_ev};
      rd_ptr_reg <= rd_ptr_reg + {1'b0, out_tick};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_out_reg <= 1'b0;
      a_out_reg  <= 16'h0000;
      b_out_reg  <= 16'h0000;
    end else if (out_tick) begin
      st_out_reg <= st_src; // [R7] [R13]
      a_out_reg  <= a_src;
      b_out_reg  <= b_src;
    end
  end

  // Only one reset can be in flight; a newer edge restarts the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_prev_reg <= 1'b0;
      pend_reg    <= 4'h0;
      acc_reg     <= 32'h0000_0000;
    end else begin
      st_prev_reg <= st_out_reg;
      if (st_rise) begin
        pend_reg <= OSC_LATENCY; // [R9] [R10]
      end else if (osc_tick && pend_reg != 4'h0) begin
        pend_reg <= pend_reg - 4'h1;
      end
      if (acc_clear) begin
        acc_reg <= 32'h0000_0000; // [R22]
      end else if (osc_tick) begin
        acc_reg <= acc_reg + link.freq_word; // [R22]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_cnt_reg <= 2'h0;
      dac_a_reg  <= 16'h0000;
      dac_b_reg  <= 16'h0000;
    end else begin
      if (cm_hold) begin
        cm_cnt_reg <= 2'h0; // [R15] [R13]
      end else if (out_tick) begin
        cm_cnt_reg <= cm_cnt_reg + 2'h1; // [R12]
      end
      // Strobe to output latency is only this short pipeline, not the full filter chain.
      if (out_tick) begin
        dac_a_reg <= mixed[15:0]; // [R11]
        dac_b_reg <= mixed[31:16];
      end
    end
  end

  assign dac_a           = dac_a_reg;
  assign dac_b           = dac_b_reg;
  assign osc_phase       = acc_reg;
  assign link.rate_clock = rate_clk_reg;
  assign link.acc_phase  = acc_reg;
endmodule

// File: sync_pkg.sv
// Shared constants for the phase strobe synchronisation pair.
// Assumes both ends run on one clock, pclk.
package sync_pkg;
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  FREQ_OFS      = 4'h4;
  localparam logic [3:0]  DATA_OFS      = 4'h8;
  localparam logic [3:0]  STATUS_OFS    = 4'hc;
  localparam int          PLL_BIT       = 0;
  localparam int          SKIP_BIT      = 1;
  localparam int          TWOCLK_BIT    = 2;
  localparam int          EDGE_BIT      = 3;
  localparam int          INTERP_LSB    = 4;
  localparam int          OSYNC_BIT     = 6;
  localparam int          MSYNC_BIT     = 7;
  localparam int          START_LSB     = 8;
  localparam int          FMSEL_LSB     = 10;
  localparam int          STROBE_BIT    = 14;
  localparam int          INIT_BIT      = 15;
  localparam logic [15:0] CTRL_RESET    = 16'h0002;
  localparam logic [1:0]  INTERP_2X     = 2'h0;
  localparam logic [1:0]  INTERP_4X     = 2'h1;
  localparam logic [1:0]  INTERP_4XLOW  = 2'h2;
  localparam logic [1:0]  INTERP_8X     = 2'h3;
  localparam logic [1:0]  MIX_OFF       = 2'h0;
  localparam logic [1:0]  MIX_HALF      = 2'h1;
  localparam logic [1:0]  MIX_QUARTER   = 2'h2;
  localparam logic [1:0]  MIX_NQUARTER  = 2'h3;
  localparam logic [3:0]  OSC_LATENCY   = 4'hd;
  localparam logic [1:0]  INIT_WR_PTR   = 2'h2;
  localparam logic [1:0]  INIT_RD_PTR   = 2'h0;
  localparam int          BUF_DEPTH     = 4;

  // Rate clock division for each interpolation setting.
  function automatic logic [3:0] div_of(input logic [1:0] m);
    case (m)
      INTERP_2X: div_of = 4'h2;
      INTERP_8X: div_of = 4'h8;
      default:   div_of = 4'h4;
    endcase
  endfunction
endpackage

// File: sync_link_if.sv
// Link between the upstream source and the converter sync logic.
// Assumes the bench joins both modports and supplies pclk.
`timescale 1ns/1ps
interface sync_link_if;
  logic        input_rate_clock;
  logic        phase_strobe;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic        pll_supply_pin;
  logic        buffer_skip;
  logic        two_clock_select;
  logic        edge_invert;
  logic [1:0]  interp_mode;
  logic        osc_sync_enable;
  logic        fixed_mixer_sync_enable;
  logic [1:0]  start_phase;
  logic [3:0]  fixed_mixer_select;
  logic [31:0] freq_word;
  logic        buffer_init;
  logic        rate_clock;
  logic [31:0] acc_phase;
  modport device (input input_rate_clock, phase_strobe, word_a, word_b, pll_supply_pin,
                  buffer_skip, two_clock_select, edge_invert, interp_mode, osc_sync_enable,
                  fixed_mixer_sync_enable, start_phase, fixed_mixer_select, freq_word,
                  buffer_init, output rate_clock, acc_phase);
  modport source (output input_rate_clock, phase_strobe, word_a, word_b, pll_supply_pin,
                  buffer_skip, two_clock_select, edge_invert, interp_mode, osc_sync_enable,
                  fixed_mixer_sync_enable, start_phase, fixed_mixer_select, freq_word,
                  buffer_init, input rate_clock, acc_phase);
endinterface

// File: strobe_sync_source.sv
// Source end: APB register slave driving clocks, strobe, words and settings.
// Assumes an APB master on pclk and the converter end on the same link.
`timescale 1ns/1ps
module strobe_sync_source
  import sync_pkg::*;
(
  input  wire logic        pclk,    // system clock
  input  wire logic        presetn, // async reset, low active
  sync_link_if.source      link,    // link to converter
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB direction
  input  wire logic [31:0] paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr  // APB error
);
  logic [15:0] ctrl_reg;
  logic [15:0] cfg_reg;
  logic [31:0] freq_reg;
  logic [31:0] data_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        init_reg;
  logic [3:0]  clk_cnt_reg;
  logic        inclk_reg;

  wire        access  = psel && penable;
  wire        done    = access && pready_reg;
  wire        hit_c   = (paddr[31:4] == 28'h0) && (paddr[3:0] == CTRL_OFS);
  wire        hit_f   = (paddr[31:4] == 28'h0) && (paddr[3:0] == FREQ_OFS);
  wire        hit_d   = (paddr[31:4] == 28'h0) && (paddr[3:0] == DATA_OFS);
  wire        hit_s   = (paddr[31:4] == 28'h0) && (paddr[3:0] == STATUS_OFS);
  wire        mapped  = hit_c || hit_f || hit_d || hit_s;
  wire [31:0] rd_mux  = hit_c ? {16'h0000, ctrl_reg} : hit_f ? freq_reg :
                        hit_d ? data_reg : hit_s ? link.acc_phase : 32'h0000_0000;
  wire        pll     = ctrl_reg[PLL_BIT];
  wire        twoclk  = ctrl_reg[TWOCLK_BIT];
  // PLL mode keeps the buffer bypassed; dual modes tie invert to buffer use.
  wire        skip    = pll || ctrl_reg[SKIP_BIT]; // [R6]
  wire        edge_b  = (!pll && twoclk) ? !skip : ctrl_reg[EDGE_BIT]; // [R4] [R5]
  wire [15:0] cfg_nxt = {ctrl_reg[15:4], edge_b, twoclk && !pll, skip, pll};
  // Divide by the registered setting, so the input clock switches in step with the converter.
  wire [3:0]  div_n   = div_of(cfg_reg[INTERP_LSB +: 2]);
  wire        wrap    = (clk_cnt_reg >= div_n - 4'h1);
  wire [3:0]  cnt_nxt = wrap ? 4'h0 : clk_cnt_reg + 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= access && !pready_reg;
      prdata_reg  <= rd_mux;
      pslverr_reg <= access && !pready_reg && !mapped;
    end
  end

  // Init is a one-cycle pulse; the strobe bit is a level held by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      freq_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
      init_reg <= 1'b0;
    end else begin
      init_reg <= done && pwrite && hit_c && pwdata[INIT_BIT]; // [R3] [R5]
      if (done && pwrite && hit_c) begin
        ctrl_reg <= {1'b0, pwdata[14:0]}; // [R16]
      end
      if (done && pwrite && hit_f) begin
        freq_reg <= pwdata;
      end
      if (done && pwrite && hit_d) begin
        data_reg <= pwdata;
      end
    end
  end

  // The input clock is divided from pclk, so its edges align with it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= CTRL_RESET;
      clk_cnt_reg <= 4'h0;
      inclk_reg   <= 1'b0;
    end else begin
      cfg_reg     <= cfg_nxt;
      clk_cnt_reg <= cnt_nxt; // [R20]
      inclk_reg   <= (cnt_nxt < (div_n >> 1)); // [R20]
    end
  end

  assign prdata                       = prdata_reg;
  assign pready                       = pready_reg;
  assign pslverr                      = pslverr_reg;
  assign link.input_rate_clock        = inclk_reg;
  assign link.phase_strobe            = cfg_reg[STROBE_BIT];
  assign link.word_a                  = data_reg[15:0];
  assign link.word_b                  = data_reg[31:16];
  assign link.pll_supply_pin          = cfg_reg[PLL_BIT];
  assign link.buffer_skip             = cfg_reg[SKIP_BIT];
  assign link.two_clock_select        = cfg_reg[TWOCLK_BIT];
  assign link.edge_invert             = cfg_reg[EDGE_BIT];
  assign link.interp_mode             = cfg_reg[INTERP_LSB +: 2];
  assign link.osc_sync_enable         = cfg_reg[OSYNC_BIT];
  assign link.fixed_mixer_sync_enable = cfg_reg[MSYNC_BIT];
  assign link.start_phase             = cfg_reg[START_LSB +: 2];
  assign link.fixed_mixer_select      = cfg_reg[FMSEL_LSB +: 4];
  assign link.freq_word               = freq_reg;
  assign link.buffer_init             = init_reg;
endmodule

// File: strobe_sync_checker.sv
// Concurrent checks on the link that joins the source and converter ends.
// Assumes the bench wires each input to the matching link signal.
`timescale 1ns/1ps
module strobe_sync_checker
  import sync_pkg::*;
(
  input wire logic        pclk,             // clock
  input wire logic        presetn,          // async reset, low active
  input wire logic        input_rate_clock, // source input clock
  input wire logic        phase_strobe,     // strobe level
  input wire logic        pll_supply_pin,   // pll mode
  input wire logic        buffer_skip,      // buffer bypass
  input wire logic        two_clock_select, // dual clock mode
  input wire logic        edge_invert,      // latch edge select
  input wire logic [1:0]  interp_mode,      // interpolation
  input wire logic        osc_sync_enable,  // oscillator sync on
  input wire logic [31:0] freq_word,        // frequency word
  input wire logic        buffer_init,      // buffer init pulse
  input wire logic        rate_clock,       // divided rate clock
  input wire logic [31:0] acc_phase         // accumulator
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A clear long after the enable dropped would mean the enable is ignored.
  logic [7:0] en_age_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_age_reg <= 8'hff;
    else if (osc_sync_enable) en_age_reg <= 8'h00;
    else if (en_age_reg != 8'hff) en_age_reg <= en_age_reg + 8'h01;
  end

  sequence low_then_high(x);
    !x ##1 x;
  endsequence
  sequence steady_2x;
    (interp_mode == INTERP_2X) [*8];
  endsequence

  a_rate_div_two: assert property (steady_2x ##0 $rose(rate_clock) |=> low_then_high(rate_clock))
    else $error("rate clock period wrong in 2x mode");
  a_rate_div_four: assert property ((interp_mode == INTERP_4X) [*8] ##0 $rose(rate_clock) |->
    rate_clock [*2] ##1 (!rate_clock) [*2] ##1 rate_clock)
    else $error("rate clock period wrong in 4x mode");
  a_input_div_two: assert property (steady_2x ##0 $rose(input_rate_clock) |=>
    low_then_high(input_rate_clock))
    else $error("input clock period wrong in 2x mode");
  a_osc_clear_window: assert property ($rose(phase_strobe) && osc_sync_enable &&
    !pll_supply_pin && buffer_skip && two_clock_select && interp_mode == INTERP_2X |->
    ##[1:80] (acc_phase == 32'h0))
    else $error("accumulator not cleared after strobe");
  a_osc_gated: assert property (acc_phase == 32'h0 && $past(acc_phase) != 32'h0 &&
    freq_word[0] |-> en_age_reg < 8'h64)
    else $error("accumulator cleared with sync disabled");
  a_acc_resumes: assert property (acc_phase == 32'h0 && $past(acc_phase) != 32'h0 |->
    ##[1:4] (acc_phase == freq_word))
    else $error("accumulator did not resume from zero");
  a_pll_bypass: assert property (pll_supply_pin && $past(pll_supply_pin) |-> buffer_skip)
    else $error("buffer used in pll mode");
  a_dual_edge_inv: assert property (two_clock_select && !pll_supply_pin &&
    $stable(buffer_skip) && $stable(two_clock_select) |-> edge_invert == !buffer_skip)
    else $error("edge invert wrong in dual clock mode");
  a_init_pulse: assert property ($rose(buffer_init) |=> !buffer_init)
    else $error("buffer init longer than one cycle");
endmodule

// File: test_phase_strobe_sync_logic.sv
// Self-checking bench for the source and converter ends joined by one link.
// Assumes the package, link interface, both ends and the checker compile first.
`timescale 1ns/1ps
module test_phase_strobe_sync_logic;
  import sync_pkg::*;
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
  localparam logic [31:0] CTRL_ADDR = {28'h0, CTRL_OFS};
  localparam logic [31:0] FREQ_ADDR = {28'h0, FREQ_OFS};
  localparam logic [31:0] DATA_ADDR = {28'h0, DATA_OFS};
  localparam logic [31:0] INIT_MASK = 32'h1 << INIT_BIT;
  // Odd step, so the accumulator never wraps onto zero by itself.
  localparam logic [31:0] FREQ_VAL  = 32'h0100_0001;
  localparam logic [15:0] A_VAL     = 16'h1234;
  localparam logic [15:0] B_VAL     = 16'h0567;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rdat, osc_phase;
  logic [15:0] dac_a, dac_b;
  int          bad_count, samples_checked;
  int          exp_div [4] = '{2, 4, 4, 8};
  sync_link_if link ();
  strobe_sync_source strobe_sync_source_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  strobe_sync_device strobe_sync_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .dac_a(dac_a), .dac_b(dac_b), .osc_phase(osc_phase));
  strobe_sync_checker strobe_sync_checker_inst (.pclk(pclk), .presetn(presetn),
    .input_rate_clock(link.input_rate_clock), .phase_strobe(link.phase_strobe),
    .pll_supply_pin(link.pll_supply_pin), .buffer_skip(link.buffer_skip),
    .two_clock_select(link.two_clock_select), .edge_invert(link.edge_invert),
    .interp_mode(link.interp_mode), .osc_sync_enable(link.osc_sync_enable),
    .freq_word(link.freq_word), .buffer_init(link.buffer_init),
    .rate_clock(link.rate_clock), .acc_phase(link.acc_phase));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] mk(input logic [3:0] md, input logic [1:0] im,
      input logic os, input logic ms, input logic [1:0] sp, input logic [3:0] fs,
      input logic stb);
    return 32'(md) | (32'(im) << INTERP_LSB) | (32'(os) << OSYNC_BIT) | (32'(ms) << MSYNC_BIT)
      | (32'(sp) << START_LSB) | (32'(fs) << FMSEL_LSB) | (32'(stb) << STROBE_BIT);
  endfunction

  function automatic logic [31:0] mixv(input logic [1:0] mx, input logic [1:0] p);
    logic [1:0] q;
    q = (mx == MIX_NQUARTER) ? 2'h0 - p : p;
    if (mx == MIX_HALF) return p[0] ? {-A_VAL, -B_VAL} : {A_VAL, B_VAL};
    case (q)
      2'h0: return {A_VAL, B_VAL};
      2'h1: return {-B_VAL, A_VAL};
      2'h2: return {-A_VAL, -B_VAL};
      default: return {B_VAL, -A_VAL};
    endcase
  endfunction

  // Starts one edge later so a release and the next setup never share a time step.
  task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err  = pslverr;
    if (pready !== 1'b1) bad_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic period(input logic use_in, output int p);
    int r1;
    logic prev, cur;
    prev = 1'b1;
    r1 = -1;
    p = 0;
    for (int n = 0; n < 40 && p == 0; n++) begin
      @(posedge pclk);
      cur = use_in ? link.input_rate_clock : link.rate_clock;
      if (cur === 1'b1 && prev === 1'b0) p = (r1 < 0) ? 0 : n - r1;
      if (cur === 1'b1 && prev === 1'b0 && r1 < 0) r1 = n;
      prev = cur;
    end
  endtask

  task automatic await_out(input logic [31:0] ex);
    for (int n = 0; n < 60 && {dac_a, dac_b} !== ex; n++) @(posedge pclk);
    `CHECK("dac_pair", ex, {dac_a, dac_b})
  endtask

  task automatic t_reset();
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHECK("ctrl_reset", {16'h0, CTRL_RESET}, rdat)
    apb(1'b0, 32'h0000_0010, 32'h0);
    `CHECK("unmapped_err", 1'b1, err)
    `CHECK("unmapped_data", 32'h0, rdat)
  endtask

  task automatic t_rate();
    int p;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_ADDR, mk(4'h2, 2'(i), 1'b0, 1'b0, 2'h0, 4'h0, 1'b0));
      repeat (10) @(posedge pclk);
      period(1'b0, p);
      `CHECK("rate_period", exp_div[i], p)
      period(1'b1, p);
      `CHECK("input_period", exp_div[i], p)
    end
  endtask

  task automatic t_nco(input logic en);
    logic hit;
    apb(1'b1, FREQ_ADDR, FREQ_VAL);
    apb(1'b1, CTRL_ADDR, mk(4'h6, INTERP_2X, en, 1'b0, 2'h0, 4'h0, 1'b0));
    repeat (20) @(posedge pclk);
    apb(1'b1, CTRL_ADDR, mk(4'h6, INTERP_2X, en, 1'b0, 2'h0, 4'h0, 1'b1));
    hit = 1'b0;
    for (int n = 0; n < 120 && !hit; n++) begin
      @(posedge pclk);
      hit = (osc_phase === 32'h0);
    end
    `CHECK("osc_cleared", en, hit)
    for (int n = 0; n < 6 && en && osc_phase === 32'h0; n++) @(posedge pclk);
    if (en) `CHECK("osc_resume", FREQ_VAL, osc_phase)
  endtask

  // Single rise, single fall, single buffered, dual bypass, dual buffered, pll.
  task automatic t_modes();
    logic [3:0] md [6] = '{4'h2, 4'ha, 4'h0, 4'h6, 4'hc, 4'h3};
    logic [15:0] a;
    for (int i = 0; i < 6; i++) begin
      a = 16'h1000 + 16'(i);
      apb(1'b1, CTRL_ADDR, mk(md[i], INTERP_2X, 1'b0, 1'b0, 2'h0, 4'h0, 1'b0));
      apb(1'b1, CTRL_ADDR, mk(md[i], INTERP_2X, 1'b0, 1'b0, 2'h0, 4'h0, 1'b0) | INIT_MASK);
      apb(1'b1, DATA_ADDR, {~a, a});
      await_out({a, ~a});
    end
  endtask

  // Strobe stays low, so the held counter leaves only the programmed offset.
  task automatic t_mixer();
    logic [1:0] mx [3] = '{MIX_HALF, MIX_QUARTER, MIX_NQUARTER};
    logic [1:0] k2;
    apb(1'b1, DATA_ADDR, {B_VAL, A_VAL});
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 8; k++) begin
        k2 = 2'(k);
        apb(1'b1, CTRL_ADDR, mk(4'h2, INTERP_2X, 1'b0, 1'b1, (k < 4) ? k2 : 2'h0,
          {mx[j], (k < 4) ? 2'h0 : k2}, 1'b0));
        await_out(mixv(mx[j], k2));
      end
    end
  endtask

  task automatic t_run(input logic ms, input logic stb, input logic exp_run);
    logic pos, neg;
    apb(1'b1, CTRL_ADDR, mk(4'h2, INTERP_2X, 1'b0, ms, 2'h0, {MIX_HALF, 2'h0}, stb));
    repeat (10) @(posedge pclk);
    pos = 1'b0;
    neg = 1'b0;
    repeat (16) begin
      @(posedge pclk);
      pos |= (dac_a === A_VAL);
      neg |= (dac_a === -A_VAL);
    end
    `CHECK("mixer_runs", exp_run, pos & neg)
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rate();
    t_nco(1'b1);
    t_nco(1'b0);
    t_modes();
    t_mixer();
    t_run(1'b1, 1'b1, 1'b1);
    t_run(1'b1, 1'b0, 1'b0);
    t_run(1'b0, 1'b0, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    print_verdict();
  end

  initial begin
    #(100 * 30000);
    bad_count++;
    print_verdict();
  end
endmodule
